// file: src/pmic_gpio_alt_function.sv
// Three-pin I/O block with debounce, edge interrupts, alternate functions and an AHB-Lite register slave.
`include "gpio_params.svh"

// Operation
// - A pin is an output while its direction bit is 0 and an input while it is 1.
// - An output drives push-pull when the drive-type bit is 1 and open-drain when it is 0.
// - In open-drain mode the pin is only pulled low or released, never driven high.
// - The input-level bit always shows the pin level, whatever the direction.
// - An input has a 30 ms debounce filter, used when its enable bit is 1 and bypassed when 0.
// - Debounce time is counted on ticks of the dedicated internal oscillator.
// - Rising and falling edges on each input are detected separately as interrupt events.
// - Separate rise and fall mask bits gate the active-low interrupt, 1 blocking and 0 passing.
// - Each pin has a readable alternate-mode bit, 0 for normal use and 1 for its fixed function.
// - In alternate mode pin 0 outputs the active-high sequencer slot of regulator channel two.
// - In alternate mode pin 1 enables channel two when high, ORed with the sequencer enable.
// - With pin 1 alternate, codes 4 and 5 follow the pin and all other codes keep the channel on.
// - In alternate mode pin 2 is ORed with the bias low-power bit to request low-power mode.
// - All interrupt mask bits reset to masked.
module pmic_gpio_alt_function
    import gpio_pkg::*;
#(
    parameter int OSC_HZ = `DBNC_OSC_HZ,
    parameter int NPINS  = 3
) (
    // Clock and reset.
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    // AHB-Lite slave.
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic                  hreadyout,
    output logic                  hresp,
    output logic [31:0]           hrdata,
    // Pins: sampled level, drive value and drive enable.
    input  wire logic [NPINS-1:0] pin_in,
    output logic      [NPINS-1:0] pin_out,
    output logic      [NPINS-1:0] pin_oe,
    // Dedicated debounce oscillator.
    input  wire logic             dbnc_osc,
    // Power sequencer signals for regulator channel two.
    input  wire logic             seq_ch2_slot,
    input  wire logic             seq_ch2_en,
    // Results and interrupt.
    output logic                  ch2_enable,
    output logic                  bias_low_power,
    output logic                  irq_out_n
);
    localparam int DBNC_TICKS = (`DBNC_TIME_MS * OSC_HZ + 999) / 1000;

    pin_cfg_type              cfg_r [NPINS];
    pin_cfg_type              cfg_nxt [NPINS];
    logic [`IRQ_WIDTH-1:0]    flag_r;
    logic [`IRQ_WIDTH-1:0]    flag_nxt;
    logic [`IRQ_WIDTH-1:0]    mask_r;
    logic [`IRQ_WIDTH-1:0]    mask_nxt;
    ch2_code_type             ch2_code_r;
    ch2_code_type             ch2_code_nxt;
    logic                     bias_req_r;
    logic                     bias_req_nxt;
    logic [NPINS-1:0]         level_d_r;
    logic [NPINS-1:0]         level_d_nxt;
    logic                     osc_d_r;
    logic                     osc_d_nxt;
    logic                     wr_pend_r;
    logic                     wr_pend_nxt;
    logic                     rd_pend_r;
    logic                     rd_pend_nxt;
    logic [7:0]               addr_r;
    logic [7:0]               addr_nxt;
    logic [31:0]              rdata_r;
    logic [31:0]              rdata_nxt;
    logic                     ch2_en_r;
    logic                     ch2_en_nxt;
    logic                     bias_r;
    logic                     bias_nxt;
    logic [NPINS-1:0]         pin_sync;
    logic                     osc_sync;
    logic [NPINS-1:0]         level;
    logic [NPINS-1:0]         rise;
    logic [NPINS-1:0]         fall;
    logic [`IRQ_WIDTH-1:0]    events;
    logic                     osc_tick;
    logic                     accept;

    // Pins and oscillator come from outside the clock domain.
    sync2 #(.WIDTH(NPINS + 1)) u_sync (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .async_in ({dbnc_osc, pin_in}),
        .sync_out ({osc_sync, pin_sync})
    );

    // One tick per rising edge of the oscillator, seen after synchronising.
    assign osc_tick = osc_sync & ~osc_d_r;

    // Each pin has its own filter; it only acts while the pin is an input.
    for (genvar i = 0; i < NPINS; i++) begin : g_pin
        pin_debounce #(.DBNC_TICKS(DBNC_TICKS)) u_dbnc (
            .sys_clk   (sys_clk),
            .reset_n   (reset_n),
            .raw_in    (pin_sync[i]),
            .osc_tick  (osc_tick),
            .filter_en (cfg_r[i].input_debounce_en & cfg_r[i].dir_input),
            .level_out (level[i])
        );
    end

    // Edge detectors run on the level whatever the direction.
    assign rise   = level & ~level_d_r;
    assign fall   = ~level & level_d_r;
    assign events = {fall, rise};

    // Pin drivers: alternate function first, then direction and drive type.
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            if (cfg_r[i].alt_function_sel) begin
                pin_out[i] = (i == 0) ? seq_ch2_slot : 1'b0;
                pin_oe[i]  = (i == 0);
            end else if (cfg_r[i].dir_input) begin
                pin_out[i] = 1'b0;
                pin_oe[i]  = 1'b0;
            end else if (cfg_r[i].output_drive_type) begin
                pin_out[i] = cfg_r[i].out_val;
                pin_oe[i]  = 1'b1;
            end else begin
                pin_out[i] = 1'b0;
                pin_oe[i]  = ~cfg_r[i].out_val;
            end
        end
    end

    // Address phase is taken when selected, ready and a transfer is requested.
    assign accept = hsel & hready & htrans[1];

    // Read mux, shared by every read data phase.
    function automatic logic [31:0] read_word(input logic [7:0] a,
                                              input pin_cfg_type c0,
                                              input pin_cfg_type c1,
                                              input pin_cfg_type c2,
                                              input logic [NPINS-1:0] lvl,
                                              input logic [`IRQ_WIDTH-1:0] fl,
                                              input logic [`IRQ_WIDTH-1:0] mk,
                                              input ch2_code_type code,
                                              input logic breq,
                                              input logic ch2,
                                              input logic bias);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (a == `OFS_PIN_CFG0) begin
            w[`CFG_WIDTH-1:0] = c0;
            w[`CFG_LEVEL_BIT] = lvl[0];
        end else if (a == `OFS_PIN_CFG1) begin
            w[`CFG_WIDTH-1:0] = c1;
            w[`CFG_LEVEL_BIT] = lvl[1];
        end else if (a == `OFS_PIN_CFG2) begin
            w[`CFG_WIDTH-1:0] = c2;
            w[`CFG_LEVEL_BIT] = lvl[2];
        end else if (a == `OFS_IRQ_STATUS) begin
            w[`IRQ_WIDTH-1:0] = fl;
        end else if (a == `OFS_IRQ_MASK) begin
            w[`IRQ_WIDTH-1:0] = mk;
        end else if (a == `OFS_CH2_CFG) begin
            w[2:0] = code;
        end else if (a == `OFS_GLOBAL_CFG) begin
            w[0] = breq;
        end else if (a == `OFS_BLOCK_STATUS) begin
            w[0] = ch2;
            w[1] = bias;
        end
        return w;
    endfunction : read_word

    // Bus phases, register writes, flags and derived outputs.
    always_comb begin
        pin_cfg_type wcfg;
        logic        rd_status;
        logic        ch2_pin_follow;
        wcfg           = pin_cfg_type'(hwdata[`CFG_WIDTH-1:0]);
        rd_status      = 1'b0;
        ch2_pin_follow = 1'b0;
        cfg_nxt        = cfg_r;
        mask_nxt       = mask_r;
        ch2_code_nxt   = ch2_code_r;
        bias_req_nxt   = bias_req_r;
        level_d_nxt    = level;
        osc_d_nxt      = osc_sync;
        rdata_nxt      = rdata_r;
        wr_pend_nxt    = 1'b0;
        rd_pend_nxt    = 1'b0;
        addr_nxt       = addr_r;
        // A new address phase is only taken while no read is being answered.
        if (accept && !rd_pend_r) begin
            addr_nxt    = haddr[7:0];
            wr_pend_nxt = hwrite;
            rd_pend_nxt = ~hwrite;
        end
        // Write data phase.
        if (wr_pend_r) begin
            if (addr_r == `OFS_PIN_CFG0) begin
                cfg_nxt[0] = wcfg;
            end else if (addr_r == `OFS_PIN_CFG1) begin
                cfg_nxt[1] = wcfg;
            end else if (addr_r == `OFS_PIN_CFG2) begin
                cfg_nxt[2] = wcfg;
            end else if (addr_r == `OFS_IRQ_MASK) begin
                mask_nxt = hwdata[`IRQ_WIDTH-1:0];
            end else if (addr_r == `OFS_CH2_CFG) begin
                ch2_code_nxt = hwdata[2:0];
            end else if (addr_r == `OFS_GLOBAL_CFG) begin
                bias_req_nxt = hwdata[0];
            end
        end
        // Read data phase: data are captured once, after any earlier write has landed.
        if (rd_pend_r) begin
            rdata_nxt = read_word(addr_r, cfg_r[0], cfg_r[1], cfg_r[2], level, flag_r, mask_r,
                                  ch2_code_r, bias_req_r, ch2_en_r, bias_r);
            rd_status = (addr_r == `OFS_IRQ_STATUS);
        end
        // Flags clear on read or on a written one; a same-cycle edge still wins.
        flag_nxt = flag_r;
        if (rd_status) begin
            flag_nxt = '0;
        end
        if (wr_pend_r && addr_r == `OFS_IRQ_STATUS) begin
            flag_nxt = flag_nxt & ~hwdata[`IRQ_WIDTH-1:0];
        end
        flag_nxt = flag_nxt | events;
        // Channel-two enable under the alternate pin.
        ch2_pin_follow = (ch2_code_r == `CH2_CODE_PIN_A) || (ch2_code_r == `CH2_CODE_PIN_B);
        if (cfg_r[1].alt_function_sel) begin
            ch2_en_nxt = ch2_pin_follow ? (level[1] | seq_ch2_en) : 1'b1;
        end else begin
            ch2_en_nxt = seq_ch2_en;
        end
        // Bias low-power request from the register bit or the alternate pin.
        bias_nxt = bias_req_r | (cfg_r[2].alt_function_sel & level[2]);
        if (!reset_n) begin
            for (int i = 0; i < NPINS; i++) begin
                cfg_nxt[i] = pin_cfg_type'(`CFG_RESET);
            end
            flag_nxt     = '0;
            mask_nxt     = `IRQ_MASK_RESET;
            ch2_code_nxt = `CH2_CODE_RESET;
            bias_req_nxt = 1'b0;
            level_d_nxt  = '0;
            osc_d_nxt    = 1'b0;
            rdata_nxt    = 32'h0000_0000;
            wr_pend_nxt  = 1'b0;
            rd_pend_nxt  = 1'b0;
            addr_nxt     = 8'h00;
            ch2_en_nxt   = 1'b0;
            bias_nxt     = 1'b0;
        end
    end

    // Registers only.
    always_ff @(posedge sys_clk) begin
        cfg_r      <= cfg_nxt;
        flag_r     <= flag_nxt;
        mask_r     <= mask_nxt;
        ch2_code_r <= ch2_code_nxt;
        bias_req_r <= bias_req_nxt;
        level_d_r  <= level_d_nxt;
        osc_d_r    <= osc_d_nxt;
        rdata_r    <= rdata_nxt;
        wr_pend_r  <= wr_pend_nxt;
        rd_pend_r  <= rd_pend_nxt;
        addr_r     <= addr_nxt;
        ch2_en_r   <= ch2_en_nxt;
        bias_r     <= bias_nxt;
    end

    // A read costs one wait state so that a write just before it is always seen.
    assign hreadyout      = ~rd_pend_r;
    assign hresp          = 1'b0;
    assign hrdata         = rdata_r;
    assign ch2_enable     = ch2_en_r;
    assign bias_low_power = bias_r;

    // Open-drain style active-low interrupt: low while any unmasked flag is set.
    assign irq_out_n = ~|(flag_r & ~mask_r);
endmodule : pmic_gpio_alt_function

// file: src/gpio_params.svh
// Register offsets, field positions, reset values and timing figures of the pin block.
`ifndef GPIO_PARAMS_SVH
`define GPIO_PARAMS_SVH

// Register byte offsets on the bus.
`define OFS_PIN_CFG0      8'h00
`define OFS_PIN_CFG1      8'h04
`define OFS_PIN_CFG2      8'h08
`define OFS_IRQ_STATUS    8'h0C
`define OFS_IRQ_MASK      8'h10
`define OFS_CH2_CFG       8'h14
`define OFS_GLOBAL_CFG    8'h18
`define OFS_BLOCK_STATUS  8'h1C

// Pin configuration field positions.
`define CFG_DIR_BIT       0
`define CFG_LEVEL_BIT     1
`define CFG_OUT_VAL_BIT   2
`define CFG_DRV_BIT       3
`define CFG_DBEN_BIT      4
`define CFG_ALT_BIT       5
`define CFG_WIDTH         6

// Interrupt status and mask layout: rising flags low, falling flags above.
`define IRQ_RISE_LSB      0
`define IRQ_FALL_LSB      3
`define IRQ_WIDTH         6
`define IRQ_MASK_RESET    6'h3F

// Pin configuration reset: input, no debounce, open-drain, standard mode.
`define CFG_RESET         6'h01
`define CH2_CODE_RESET    3'h0

// Channel-two enable codes that follow the alternate pin.
`define CH2_CODE_PIN_A    3'h4
`define CH2_CODE_PIN_B    3'h5

// Debounce time and default rate of the dedicated oscillator.
`define DBNC_TIME_MS      30
`define DBNC_OSC_HZ       32768

`endif

// file: src/gpio_pkg.sv
// Types shared by the pin block modules.
package gpio_pkg;

    // One pin's configuration as software writes it.
    typedef struct packed {
        logic alt_function_sel;
        logic input_debounce_en;
        logic output_drive_type;
        logic out_val;
        logic level_unused;
        logic dir_input;
    } pin_cfg_type;

    // Channel-two enable code.
    typedef logic [2:0] ch2_code_type;

endpackage : gpio_pkg

// file: src/sync2.sv
// Two-flop synchroniser for levels that arrive from outside the clock domain.
module sync2 #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    // Asynchronous input and its synchronised copy.
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] sync_r;
    logic [WIDTH-1:0] sync_nxt;

    // The first stage feeds only the second stage.
    always_comb begin
        meta_nxt = async_in;
        sync_nxt = meta_r;
        if (!reset_n) begin
            meta_nxt = '0;
            sync_nxt = '0;
        end
    end

    // Registers only.
    always_ff @(posedge sys_clk) begin
        meta_r <= meta_nxt;
        sync_r <= sync_nxt;
    end

    assign sync_out = sync_r;
endmodule : sync2

// file: src/pin_debounce.sv
// Debounce filter for one pin, timed by ticks of the dedicated oscillator.
module pin_debounce #(
    parameter int DBNC_TICKS = 983
) (
    // Clock and reset.
    input  wire logic sys_clk,
    input  wire logic reset_n,
    // Synchronised pin, oscillator tick and filter enable.
    input  wire logic raw_in,
    input  wire logic osc_tick,
    input  wire logic filter_en,
    // Filtered level.
    output logic      level_out
);
    localparam int CW = $clog2(DBNC_TICKS + 1);

    logic          level_r;
    logic          level_nxt;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;

    // A change must hold for the full count of oscillator ticks before it passes.
    always_comb begin
        level_nxt = level_r;
        cnt_nxt   = cnt_r;
        if (!filter_en) begin
            level_nxt = raw_in; // Bypass costs one clock of delay for clean sources.
            cnt_nxt   = '0;
        end else if (raw_in == level_r) begin
            cnt_nxt = '0; // Any bounce back restarts the wait.
        end else if (osc_tick) begin
            if (cnt_r >= CW'(DBNC_TICKS - 1)) begin
                level_nxt = raw_in;
                cnt_nxt   = '0;
            end else begin
                cnt_nxt = cnt_r + CW'(1);
            end
        end
        if (!reset_n) begin
            level_nxt = 1'b0;
            cnt_nxt   = '0;
        end
    end

    // Registers only.
    always_ff @(posedge sys_clk) begin
        level_r <= level_nxt;
        cnt_r   <= cnt_nxt;
    end

    assign level_out = level_r;
endmodule : pin_debounce

// file: verif/pin_world.sv
// Board model around the three pins: pull-ups, outside drivers and the debounce oscillator.
module pin_world (
    // Design side of the pins.
    input  wire logic [2:0] pin_out,
    input  wire logic [2:0] pin_oe,
    // Outside drivers, enabled per pin.
    input  wire logic [2:0] ext_en,
    input  wire logic [2:0] ext_val,
    // Resolved wire levels and the oscillator.
    output logic      [2:0] pin_level,
    output logic            osc
);
    timeunit 1ns;
    timeprecision 1ps;

    // Wired-AND with a pull-up: an undriven pin reads high, any low driver wins.
    always_comb begin
        pin_level = (~pin_oe | pin_out) & (~ext_en | ext_val);
    end

    // Free-running oscillator, unrelated in phase to the system clock.
    initial osc = 1'b0;
    always #19 osc = ~osc;
endmodule : pin_world

// file: verif/pmic_gpio_alt_function_properties.sv
// Concurrent checks on the ports of the pin block.
module pmic_gpio_alt_function_properties #(
    parameter int NPINS = 3
) (
    // Clock and reset.
    input wire logic             sys_clk,
    input wire logic             reset_n,
    // Bus signals.
    input wire logic             hsel,
    input wire logic [1:0]       htrans,
    input wire logic             hwrite,
    input wire logic             hready,
    input wire logic             hreadyout,
    input wire logic             hresp,
    input wire logic [31:0]      hrdata,
    // Pins, sequencer and results.
    input wire logic [NPINS-1:0] pin_out,
    input wire logic [NPINS-1:0] pin_oe,
    input wire logic             seq_ch2_slot,
    input wire logic             seq_ch2_en,
    input wire logic             ch2_enable,
    input wire logic             irq_out_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       took;
    logic [2:0] took_r;
    logic [2:0] took_nxt;

    // A transfer is taken when selected, ready and not idle.
    always_comb begin
        took     = hsel & hready & htrans[1];
        took_nxt = {took_r[1:0], took};
    end

    // History of taken transfers, since writes and status reads act up to three edges later.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            took_r <= 3'h0;
        end else begin
            took_r <= took_nxt;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    a_irq_reset_masked: assert property ($rose(reset_n) |-> irq_out_n [*3])
        else $error("interrupt asserted right after reset");
    a_read_one_wait: assert property (took && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read did not take exactly one wait state");
    a_write_no_wait: assert property (took && hwrite |=> hreadyout)
        else $error("write data phase was stalled");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("response other than okay");
    a_ch2_seq_on: assert property (seq_ch2_en |=> ch2_enable)
        else $error("sequencer enable did not turn channel two on");
    a_irq_flag_held: assert property (!irq_out_n && !took && took_r == 3'h0 |=> !irq_out_n)
        else $error("interrupt released without any bus access");
    a_pin_drive_cause: assert property ($changed(pin_out) || $changed(pin_oe) |->
        $changed(seq_ch2_slot) || took_r != 3'h0)
        else $error("pin drive changed without a cause");
    a_rdata_after_wait: assert property ($changed(hrdata) |-> $past(hreadyout) == 1'b0)
        else $error("read data changed outside a read");

    // Main scenarios reached.
    cover property (ch2_enable && !seq_ch2_en);
    cover property ($fell(irq_out_n));
    cover property (took && !hwrite ##2 hreadyout);
endmodule : pmic_gpio_alt_function_properties

bind pmic_gpio_alt_function pmic_gpio_alt_function_properties #(.NPINS(NPINS)) props (
    .sys_clk, .reset_n, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata, .pin_out,
    .pin_oe, .seq_ch2_slot, .seq_ch2_en, .ch2_enable, .irq_out_n);

// file: verif/pmic_gpio_alt_function_tb.sv
// Self-checking bench: bus tasks, a board model and a register-level reference for the pin block.
`include "gpio_params.svh"
module pmic_gpio_alt_function_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk, reset_n, hsel, hwrite, hready, hreadyout, hresp, rdy_q;
    logic [31:0] haddr, hwdata, hrdata, rdata_q, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize, pin_lvl, pin_out, pin_oe, ext_en, ext_val;
    logic        dbnc_osc, seq_ch2_slot, seq_ch2_en, ch2_enable, bias_low_power, irq_out_n;
    int          mismatches, samples_checked, seed, exp_v;
    int          cfg [3];

    assign hready = hreadyout;

    // Short debounce count keeps the run brief: three oscillator ticks.
    pmic_gpio_alt_function #(.OSC_HZ(100), .NPINS(3)) dut (
        .sys_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
        .hresp, .hrdata, .pin_in(pin_lvl), .pin_out, .pin_oe, .dbnc_osc, .seq_ch2_slot, .seq_ch2_en,
        .ch2_enable, .bias_low_power, .irq_out_n);
    pin_world board (.pin_out, .pin_oe, .ext_en, .ext_val, .pin_level(pin_lvl), .osc(dbnc_osc));

    // System clock, 4 ns period.
    initial sys_clk = 1'b0;
    always #2 sys_clk = ~sys_clk;

    // Bus answers are copied half a cycle early, so tasks see what stood at the rising edge.
    always @(negedge sys_clk) begin
        rdy_q   <= hreadyout;
        rdata_q <= hrdata;
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results

    // Bounded wait for ready; running out counts as a failure and ends the run.
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (rdy_q !== 1'b1 && n < 64);
        if (rdy_q !== 1'b1) begin
            mismatches++;
            results();
        end
    endtask : wait_rdy

    // One single transfer: address phase held until ready, then the data phase.
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        hwrite <= wr;
        htrans <= 2'h2;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = rdata_q;
    endtask : xfer

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h00000000);
        check(nm, rd, e);
    endtask : rdc

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : tick

    task automatic wait_irq();
        int n;
        n = 0;
        while (irq_out_n !== 1'b0 && n < 20) begin
            @(posedge sys_clk);
            n++;
        end
        check("irq asserted", irq_out_n, 1'b0);
    endtask : wait_irq

    // Expected configuration readback: written fields plus the live level in bit 1.
    function automatic logic [31:0] cfg_rb(input int i, input logic lvl);
        return (32'(cfg[i]) & 32'h0000003D) | {30'h0, lvl, 1'b0};
    endfunction : cfg_rb

    // Main sequence.
    initial begin
        seed = 17;
        reset_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        ext_en = 3'h7;
        ext_val = 3'h0;
        seq_ch2_slot = 1'b0;
        seq_ch2_en = 1'b0;
        cfg = '{1, 1, 1};
        tick(10);
        reset_n <= 1'b1;
        tick(1);
        // Reset values, after an unmapped write that must leave no trace.
        xfer(1'b1, 8'h20, 32'hFFFFFFFF);
        for (int a = 0; a < 9; a++) begin
            exp_v = (a < 3) ? 1 : (a == 4) ? `IRQ_MASK_RESET : 0;
            rdc("reset value", 8'(a * 4), exp_v);
        end
        check("irq idle", irq_out_n, 1'b1);
        // Every pin as push-pull and open-drain output at both values, then pulled low outside.
        for (int i = 0; i < 3; i++) begin
            ext_en[i] <= 1'b0;
            for (int m = 0; m < 4; m++) begin
                cfg[i] = (m[1] ? 0 : 8) + m[0] * 4;
                xfer(1'b1, 8'(i * 4), cfg[i]);
                tick(8);
                check("drive enable", pin_oe[i], !(m[1] && m[0]));
                check("wire level", pin_lvl[i], m[0]);
                rdc("level readback", 8'(i * 4), cfg_rb(i, m[0]));
            end
            ext_en[i] <= 1'b1;
            tick(8);
            rdc("wired low", 8'(i * 4), cfg_rb(i, 1'b0));
            cfg[i] = 1;
            xfer(1'b1, 8'(i * 4), 32'h00000001);
        end
        // Each edge kind alone unmasked pulls the interrupt until the status is read.
        for (int e = 0; e < 6; e++) begin
            xfer(1'b0, 8'h0C, 32'h00000000);
            xfer(1'b1, 8'h10, 32'h0000003F & ~(32'h00000001 << e));
            ext_val[e % 3] <= (e >= 3);
            tick(8);
            check("irq masked", irq_out_n, 1'b1);
            ext_val[e % 3] <= (e < 3);
            wait_irq();
            ext_val[e % 3] <= (e >= 3);
            tick(12);
            check("irq held", irq_out_n, 1'b0);
            rdc("edge flags", 8'h0C, (32'h00000001 << e) | (32'h00000001 << ((e + 3) % 6)));
            check("irq cleared", irq_out_n, 1'b1);
        end
        xfer(1'b1, 8'h10, `IRQ_MASK_RESET);
        // A short glitch is ignored with the filter on; a steady level gets through later.
        ext_val <= 3'h0;
        cfg[0] = 32'h11;
        xfer(1'b1, 8'h00, cfg[0]);
        tick(40);
        ext_val[0] <= 1'b1;
        tick(4);
        ext_val[0] <= 1'b0;
        tick(40);
        rdc("glitch", 8'h00, cfg_rb(0, 1'b0));
        ext_val[0] <= 1'b1;
        tick(8);
        rdc("still filtering", 8'h00, cfg_rb(0, 1'b0));
        tick(60);
        rdc("debounced", 8'h00, cfg_rb(0, 1'b1));
        // Pin 0 as sequencer slot output follows random slot values.
        ext_en[0] <= 1'b0;
        cfg[0] = 32'h20;
        xfer(1'b1, 8'h00, cfg[0]);
        for (int k = 0; k < 8; k++) begin
            seq_ch2_slot <= 1'($random(seed));
            tick(2);
            check("slot output", {pin_oe[0], pin_lvl[0]}, {1'b1, seq_ch2_slot});
        end
        tick(8);
        rdc("alt readback", 8'h00, cfg_rb(0, seq_ch2_slot));
        // Pin 1 as channel-two enable under every code, pin level and sequencer enable.
        cfg[1] = 32'h21;
        xfer(1'b1, 8'h04, cfg[1]);
        for (int c = 0; c < 32; c++) begin
            ext_val[1] <= c[3];
            seq_ch2_en <= c[4];
            xfer(1'b1, 8'h14, c & 7);
            tick(8);
            exp_v = c[4] | ((c[2:0] == 4 || c[2:0] == 5) ? c[3] : 1);
            check("channel two enable", ch2_enable, exp_v[0]);
        end
        // Pin 2 ORed with the bias low-power request bit.
        cfg[2] = 32'h21;
        xfer(1'b1, 8'h08, cfg[2]);
        for (int b = 0; b < 4; b++) begin
            ext_val[2] <= b[1];
            xfer(1'b1, 8'h18, b & 1);
            tick(8);
            check("bias request", bias_low_power, b[0] | b[1]);
            rdc("block status", 8'h1C, {30'h0, b[0] | b[1], 1'b1});
        end
        results();
    end
endmodule : pmic_gpio_alt_function_tb
